/* File: sms_mode_fsm.sv */
// operating-mode state machine with reset output and config latching
// Summary of operation
// - six modes; field cleared in restart
// - power-up enters init, long window
// - restart to normal after delay
// - fail-safe: regulator off until wake or falling overtemperature
// - test pin low in init halts watchdog
// - pull-down, filter, latch at reset rise
// - config re-latches at every reset rise while power-on flag set
// - unstable pin gives config zero
// - config one: failure restarts
// - config zero: failure to fail-safe, watchdog on second failure if count-select clear
// - enabled overvoltage: flag, fail, mode
// - disabled overvoltage only sets flag
// - config kept once power-on flag cleared
// - count-select and config readable
// - first command in init goes normal
// - missed trigger means restart or fail-safe, by config
// - wake discarded during init
// - quiet flags during power-up
// - reset low while regulator low
// - restart: reset low, window, period
`timescale 1ns/100ps
`default_nettype none
module sms_mode_fsm
    import sms_pkg::*;
#(
    parameter int RESET_DELAY  = RESET_DELAY_CYC,
    parameter int LONG_WINDOW  = LONG_WINDOW_CYC
)(
    // clock, power-on reset and enable
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clkEn,
    input  wire logic       cmdValid,
    input  wire logic       cmdModeWr,
    input  wire logic [1:0] cmdMode,
    input  wire logic       cmdWdTrigger,
    // software control bits
    input  wire logic       countSelect,
    input  wire logic       overvoltageResetEnable,
    input  wire logic       powerOnFlagClr,
    input  wire logic       overvoltageFlagClr,
    input  wire logic       undervoltageFlagClr,
    // analog and pin conditions
    input  wire logic       mainRegulatorBelowReset,
    input  wire logic       supplyBelowShortThresh,
    input  wire logic       mainOvervoltage,
    input  wire logic       wakeEvent,
    input  wire logic       overtempActive,
    input  wire logic       testPinLow,
    input  wire logic       intPinIn,
    // pins
    output logic            mcuResetLine_n,
    output logic            intPullDownOe_n,
    output logic            failOutputs,
    output logic            mainRegulatorOn,
    // status
    output logic [2:0]      modeState,
    output logic [1:0]      modeField,
    output logic            configPinLevel,
    output logic            countSelectReadback,
    output logic            developmentMode,
    output logic            powerOnFlag,
    output logic            mainOvervoltageFlag,
    output logic            mainUndervoltageFlag,
    output logic            wakeReported,
    output logic            watchdogFailFlag,
    output logic [2:0]      watchdogPeriod
);
    sms_cfg_if cfgBus ();
    sms_mode_t  mode_ff;
    sms_mode_t  nxt_mode;
    logic [1:0] modeField_ff;
    logic [CNT_W-1:0] delayCnt_ff;
    logic [CNT_W-1:0] wdCnt_ff;
    logic       wdRun_ff;
    logic       resetOut_ff;
    logic       resetOutPrev_ff;
    logic       cfgPin_ff;
    logic       otPrev_ff;
    logic       devMode_ff;
    logic       porFlag_ff;
    logic       ovFlag_ff;
    logic       uvFlag_ff;
    logic       fail_ff;
    logic [1:0] failCnt_ff;
    logic       wake_ff;
    logic       wdFail_ff;
    logic [2:0] wdPeriod_ff;
    logic       pullDown_ff;
    logic       cfgFlt_ff;
    logic       powerUpDone_ff;
    logic       wdExpire, ovAct, modeLive, failIsFirst, delayDone, resetRise, failFailsafe;
    sms_cfg_filter uFilter (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .intPinIn (intPinIn),
        .cfg      (cfgBus.filt)
    );
    assign cfgBus.sampleEn = pullDown_ff;
    // watchdog window expiry, halted in development mode
    assign wdExpire = wdRun_ff && !devMode_ff && (wdCnt_ff >= CNT_W'(LONG_WINDOW - 1));
    assign modeLive = mode_ff != MODE_RESTART && mode_ff != MODE_FAILSAFE;
    // overvoltage acts only with the enable set
    assign ovAct = overvoltageResetEnable && mainOvervoltage && modeLive;
    assign failIsFirst = (failCnt_ff == FAIL_CNT_RST);
    // config zero, two-failure setting: first failure restarts instead
    assign failFailsafe = !cfgPin_ff && (countSelect || !failIsFirst);
    assign delayDone = (delayCnt_ff >= CNT_W'(RESET_DELAY - 1));
    assign resetRise = resetOut_ff && !resetOutPrev_ff;
    // mode transitions
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            MODE_INIT: begin
                if (cmdValid) begin
                    nxt_mode = MODE_NORMAL;
                end
            end
            MODE_NORMAL, MODE_STOP: begin
                if (cmdValid && cmdModeWr) begin
                    unique case (cmdMode)
                        MODE_REQ_NORMAL: nxt_mode = MODE_NORMAL;
                        MODE_REQ_STOP:   nxt_mode = MODE_STOP;
                        // stop cannot go straight to sleep
                        MODE_REQ_SLEEP:  nxt_mode = (mode_ff == MODE_STOP) ? MODE_RESTART : MODE_SLEEP;
                        MODE_REQ_RESET:  nxt_mode = MODE_RESTART;
                    endcase
                end
            end
            MODE_SLEEP: begin
                if (wakeEvent) begin
                    nxt_mode = MODE_RESTART;
                end
            end
            MODE_RESTART: begin
                // leave after reset delay once regulator is up
                if (delayDone && !mainRegulatorBelowReset) begin
                    nxt_mode = MODE_NORMAL;
                end
            end
            MODE_FAILSAFE: begin
                // wake or falling overtemperature ends fail-safe
                if (wakeEvent || otPrev_ff && !overtempActive) begin
                    nxt_mode = MODE_RESTART;
                end
            end
        endcase
        // failures override software requests
        if (modeLive) begin
            if (ovAct) begin
                nxt_mode = cfgPin_ff ? MODE_RESTART : MODE_FAILSAFE;
            end else if (wdExpire) begin
                nxt_mode = failFailsafe ? MODE_FAILSAFE : MODE_RESTART;
            end
        end
    end
    // mode register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= MODE_INIT;
        end else if (clkEn) begin
            mode_ff <= nxt_mode;
        end
    end
    // mode field set by software, cleared in restart
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            modeField_ff <= MODE_REQ_NORMAL;
        end else if (clkEn) begin
            if (mode_ff == MODE_RESTART) begin
                modeField_ff <= MODE_REQ_NORMAL;
            end else if (cmdValid && cmdModeWr && mode_ff != MODE_INIT) begin
                modeField_ff <= cmdMode;
            end
        end
    end
    // reset delay counted in restart and init
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            delayCnt_ff <= '0;
        end else if (clkEn) begin
            if (mainRegulatorBelowReset || (mode_ff != MODE_RESTART && mode_ff != MODE_INIT)
                || resetOut_ff) begin
                delayCnt_ff <= '0;
            end else if (!delayDone) begin
                delayCnt_ff <= delayCnt_ff + 1'b1;
            end
        end
    end
    // reset output, low in restart or regulator low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resetOut_ff     <= 1'b0;
            resetOutPrev_ff <= 1'b0;
        end else if (clkEn) begin
            resetOutPrev_ff <= resetOut_ff;
            // held low while regulator below threshold
            if (mainRegulatorBelowReset || nxt_mode == MODE_RESTART && mode_ff != MODE_RESTART
                || mode_ff == MODE_FAILSAFE || mode_ff == MODE_SLEEP) begin
                resetOut_ff <= 1'b0;
            end else if (!resetOut_ff && delayDone) begin
                resetOut_ff <= 1'b1;
            end
        end
    end
    // pull-down in reset delay, flag set
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pullDown_ff <= 1'b0;
        end else if (clkEn) begin
            pullDown_ff <= !resetOut_ff && !mainRegulatorBelowReset && porFlag_ff;
        end
    end
    // config latch at reset rise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // power-on loads the default config; reset rise may relatch it
            cfgPin_ff     <= CFG_PIN_DEFAULT;
            cfgFlt_ff     <= 1'b0;
        end else if (clkEn) begin
            if (pullDown_ff) begin
                cfgFlt_ff <= cfgBus.stable ? cfgBus.level : CFG_PIN_DEFAULT;
            end
            // latch on reset rise while power-on flag set
            if (resetRise && porFlag_ff) begin
                cfgPin_ff     <= cfgFlt_ff;
            end
        end
    end
    // development mode from test pin in init
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            devMode_ff <= 1'b0;
        end else if (clkEn) begin
            if (mode_ff == MODE_INIT && testPinLow) begin
                devMode_ff <= 1'b1;
            end
        end
    end
    // watchdog long window, restarted at reset rise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCnt_ff    <= '0;
            wdRun_ff    <= 1'b0;
            wdPeriod_ff <= WD_PERIOD_DEFAULT;
        end else if (clkEn) begin
            if (resetRise) begin
                wdCnt_ff    <= '0;
                wdRun_ff    <= 1'b1;
                wdPeriod_ff <= WD_PERIOD_DEFAULT;
            end else if (cmdValid && cmdWdTrigger || nxt_mode == MODE_RESTART
                         || mode_ff == MODE_SLEEP || mode_ff == MODE_FAILSAFE) begin
                // trigger ends the long window; further timing lives elsewhere
                wdCnt_ff <= '0;
                wdRun_ff <= 1'b0;
            end else if (wdRun_ff && !devMode_ff && !wdExpire) begin
                wdCnt_ff <= wdCnt_ff + 1'b1;
            end
        end
    end
    // failure count survives restarts, cleared at power-on only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            failCnt_ff <= FAIL_CNT_RST;
            fail_ff    <= 1'b0;
            wdFail_ff  <= 1'b0;
        end else if (clkEn) begin
            if (ovAct) begin
                // fail outputs on overvoltage with enable
                fail_ff <= 1'b1;
            end else if (wdExpire && modeLive) begin
                wdFail_ff <= 1'b1;
                if (failIsFirst) begin
                    failCnt_ff <= 2'h1;
                end else begin
                    failCnt_ff <= 2'h2;
                end
                // count-select picks first or second failure
                if (countSelect || !failIsFirst) begin
                    fail_ff <= 1'b1;
                end
            end
        end
    end
    // power-on and voltage flags; hardware set wins over clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            porFlag_ff     <= 1'b1;
            ovFlag_ff      <= 1'b0;
            uvFlag_ff      <= 1'b0;
            powerUpDone_ff <= 1'b0;
            otPrev_ff      <= 1'b0;
        end else if (clkEn) begin
            if (powerOnFlagClr) begin
                porFlag_ff <= 1'b0;
            end
            if (mainOvervoltage) begin
                ovFlag_ff <= 1'b1;
            end else if (overvoltageFlagClr) begin
                ovFlag_ff <= 1'b0;
            end
            if (resetRise) begin
                powerUpDone_ff <= 1'b1;
            end
            otPrev_ff <= overtempActive;
            // no undervoltage flag during power-up ramp
            if (mainRegulatorBelowReset && (powerUpDone_ff || !supplyBelowShortThresh)) begin
                uvFlag_ff <= 1'b1;
            end else if (undervoltageFlagClr) begin
                uvFlag_ff <= 1'b0;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
        end else if (clkEn) begin
            if (wakeEvent && mode_ff != MODE_INIT) begin
                wake_ff <= 1'b1;
            end else if (cmdValid && mode_ff != MODE_INIT) begin
                wake_ff <= 1'b0;
            end
        end
    end
    // output registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mainRegulatorOn     <= 1'b1;
            intPullDownOe_n     <= 1'b1;
            modeState           <= 3'h0;
            countSelectReadback <= 1'b0;
        end else if (clkEn) begin
            // regulator off in fail-safe and sleep
            mainRegulatorOn     <= (nxt_mode != MODE_FAILSAFE) && (nxt_mode != MODE_SLEEP);
            intPullDownOe_n     <= !(!resetOut_ff && !mainRegulatorBelowReset && porFlag_ff);
            modeState           <= 3'(nxt_mode);
            countSelectReadback <= countSelect;
        end
    end
    assign mcuResetLine_n = resetOut_ff;
    assign failOutputs = fail_ff;
    assign modeField = modeField_ff;
    assign configPinLevel = cfgPin_ff;
    assign developmentMode = devMode_ff;
    assign powerOnFlag = porFlag_ff;
    assign mainOvervoltageFlag = ovFlag_ff;
    assign mainUndervoltageFlag = uvFlag_ff;
    assign wakeReported = wake_ff;
    assign watchdogFailFlag = wdFail_ff;
    assign watchdogPeriod = wdPeriod_ff;
endmodule
`default_nettype wire

/* File: sms_pkg.sv */
// constants and types for the mode state machine
package sms_pkg;
    // operating modes
    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } sms_mode_t;

    // mode field encodings written by software
    localparam logic [1:0] MODE_REQ_NORMAL = 2'h0;
    localparam logic [1:0] MODE_REQ_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_REQ_STOP   = 2'h2;
    localparam logic [1:0] MODE_REQ_RESET  = 2'h3;

    // clock and durations
    localparam int CLK_PERIOD_NS    = 50;
    localparam int RESET_DELAY_US   = 10;
    localparam int LONG_WINDOW_MS   = 200;
    localparam int CFG_FILTER_US    = 2;
    localparam int RESET_DELAY_CYC  = (RESET_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_WINDOW_CYC  = (LONG_WINDOW_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CFG_FILTER_CYC   = (CFG_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter widths
    localparam int CNT_W            = 24;
    localparam int FLT_W            = 8;

    // values after reset; watchdog period also on restart
    localparam logic [2:0] WD_PERIOD_DEFAULT = 3'h4;
    localparam logic       CFG_PIN_DEFAULT   = 1'h0;
    localparam logic [1:0] FAIL_CNT_RST      = 2'h0;
endpackage

/* File: sms_cfg_if.sv */
// carrier between the main block and the configuration filter
`timescale 1ns/100ps
`default_nettype none
interface sms_cfg_if;
    logic sampleEn;
    logic stable;
    logic level;
    modport main (output sampleEn, input stable, level);
    modport filt (input sampleEn, output stable, level);
endinterface
`default_nettype wire

/* File: sms_cfg_filter.sv */
// continuous filter on the interrupt pin during the configuration window
`timescale 1ns/100ps
`default_nettype none
module sms_cfg_filter
    import sms_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    // pin and carrier
    input  wire logic intPinIn,
    sms_cfg_if.filt   cfg
);
    logic [FLT_W-1:0] stableCnt_ff;
    logic             lastLvl_ff;
    logic             stable_ff;

    // level must hold a full filter time to count as stable
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stableCnt_ff <= '0;
            lastLvl_ff   <= 1'b0;
            stable_ff    <= 1'b0;
        end else if (clkEn) begin
            if (!cfg.sampleEn) begin
                stableCnt_ff <= '0;
                stable_ff    <= 1'b0;
                lastLvl_ff   <= intPinIn;
            end else if (intPinIn != lastLvl_ff) begin
                // any toggle restarts the filter
                stableCnt_ff <= '0;
                stable_ff    <= 1'b0;
                lastLvl_ff   <= intPinIn;
            end else if (stableCnt_ff >= FLT_W'(CFG_FILTER_CYC - 1)) begin
                stable_ff    <= 1'b1;
            end else begin
                stableCnt_ff <= stableCnt_ff + 1'b1;
            end
        end
    end

    assign cfg.stable = stable_ff;
    assign cfg.level  = lastLvl_ff;
endmodule
`default_nettype wire

/* File: sms_mode_fsm_sva.sv */
// assertion checker for the operating-mode state machine
`timescale 1ns/100ps
`default_nettype none
module sms_mode_fsm_sva
    import sms_pkg::*;
#(
    parameter int RESET_DELAY = 20
)(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // watched inputs
    input wire logic       cmdValid,
    input wire logic       countSelect,
    input wire logic       overvoltageResetEnable,
    input wire logic       mainRegulatorBelowReset,
    input wire logic       supplyBelowShortThresh,
    input wire logic       mainOvervoltage,
    // watched outputs
    input wire logic       mcuResetLine_n,
    input wire logic       failOutputs,
    input wire logic       mainRegulatorOn,
    input wire logic [2:0] modeState,
    input wire logic [1:0] modeField,
    input wire logic       countSelectReadback,
    input wire logic       mainOvervoltageFlag,
    input wire logic       mainUndervoltageFlag
);
    // slack covers the latch edge after the delay
    localparam int RD_MAX = RESET_DELAY + 20;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // settled in restart, and its entry
    sequence in_restart;
        modeState == MODE_RESTART ##1 modeState == MODE_RESTART;
    endsequence
    sequence enter_restart;
        modeState != MODE_RESTART ##1 modeState == MODE_RESTART;
    endsequence
    restart_low_a: assert property (in_restart |-> !mcuResetLine_n)
        else $error("reset line high in restart");
    restart_exit_a: assert property (enter_restart |-> ##[1:RD_MAX] modeState == MODE_NORMAL)
        else $error("restart not left");
    field_clear_a: assert property (in_restart |-> modeField == MODE_REQ_NORMAL)
        else $error("mode field not cleared");
    failsafe_off_a: assert property ((modeState == MODE_FAILSAFE) [*2] |-> !mainRegulatorOn)
        else $error("regulator on in fail-safe");
    init_cmd_a: assert property (
        modeState == MODE_INIT && cmdValid && mcuResetLine_n |=> modeState == MODE_NORMAL)
        else $error("init command ignored");
    powerup_quiet_a: assert property (
        mainRegulatorBelowReset && supplyBelowShortThresh |=> !$rose(mainUndervoltageFlag) && !$rose(failOutputs))
        else $error("flag raised in power-up");
    below_reset_a: assert property (mainRegulatorBelowReset [*2] |-> !mcuResetLine_n)
        else $error("reset released below threshold");
    ov_plain_a: assert property (
        !overvoltageResetEnable && mainOvervoltage |=> $stable(failOutputs) ##1 mainOvervoltageFlag && $stable(failOutputs))
        else $error("overvoltage without enable acted");
    ov_reset_a: assert property (
        overvoltageResetEnable && mainOvervoltage && modeState inside {MODE_NORMAL, MODE_STOP}
        |-> ##[1:3] failOutputs && mainOvervoltageFlag)
        else $error("overvoltage reaction missing");
    cs_copy_a: assert property (countSelect [*2] |-> countSelectReadback)
        else $error("count select not reported");
endmodule
bind sms_mode_fsm sms_mode_fsm_sva #(.RESET_DELAY(RESET_DELAY)) chk_u (.*);
`default_nettype wire

/* File: sms_mcu_model.sv */
// controller stand-in: one trigger frame per reset release, none while skipTrig is set
`timescale 1ns/100ps
`default_nettype none
module sms_mcu_model (
    // clock, reset and reset line
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       mcuResetLine_n,
    // bench requests
    input  wire logic       skipTrig,
    input  wire logic       slowTrig,
    input  wire logic       modeReq,
    input  wire logic [1:0] modeSel,
    // decoded frames
    output logic            cmdValid,
    output logic            cmdModeWr,
    output logic [1:0]      cmdMode,
    output logic            cmdWdTrigger
);
    logic       seenHigh_ff;
    logic       armed_ff;
    logic [7:0] wait_ff;
    // one frame a pulse, trigger first
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {cmdValid, cmdModeWr, cmdWdTrigger, seenHigh_ff, armed_ff} <= '0;
            cmdMode <= 2'h0;
            wait_ff <= 8'h00;
        end else begin
            {cmdValid, cmdModeWr, cmdWdTrigger} <= '0;
            cmdMode <= ~cmdMode;
            seenHigh_ff <= mcuResetLine_n;
            if (mcuResetLine_n && !seenHigh_ff && !skipTrig) begin
                armed_ff <= 1'b1;
                wait_ff <= slowTrig ? 8'h96 : 8'h03; // slow still inside the window
            end else if (armed_ff && wait_ff != 8'h00) begin
                wait_ff <= wait_ff - 8'h01;
            end else if (armed_ff) begin
                armed_ff <= 1'b0;
                {cmdValid, cmdWdTrigger} <= 2'b11;
            end else if (modeReq) begin
                {cmdValid, cmdModeWr} <= 2'b11;
                cmdMode <= modeSel;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sms_mode_fsm_tb_top.sv */
// self-checking bench for the mode state machine
`timescale 1ns/100ps
`default_nettype none
module sms_mode_fsm_tb_top;
    import sms_pkg::*;
    localparam int RD = 60;
    logic       core_clk, rst_n, cmdValid, cmdModeWr, cmdWdTrigger, countSelect, overvoltageResetEnable;
    logic       powerOnFlagClr, overvoltageFlagClr, mainRegulatorBelowReset, supplyBelowShortThresh;
    logic       mainOvervoltage, wakeEvent, testPinLow, intPinIn, skipTrig, slowTrig, modeReq;
    logic       mcuResetLine_n, failOutputs, mainRegulatorOn, configPinLevel, countSelectReadback;
    logic       developmentMode, powerOnFlag, mainOvervoltageFlag, watchdogFailFlag, wakeReported;
    logic [1:0] cmdMode, modeSel, modeField;
    logic [2:0] modeState, prevMode, watchdogPeriod;
    sms_mode_t  expQ[$];
    int         n_mismatch = 0, num_checks = 0, cycles = 0, seed = 39080;
    // clkEn held high, freeze not exercised
    sms_mode_fsm #(.RESET_DELAY(RD), .LONG_WINDOW(200)) dut_u (
        .core_clk, .rst_n, .clkEn(1'b1), .cmdValid, .cmdModeWr, .cmdMode, .cmdWdTrigger, .countSelect,
        .overvoltageResetEnable, .powerOnFlagClr, .overvoltageFlagClr, .undervoltageFlagClr(1'b0),
        .mainRegulatorBelowReset, .supplyBelowShortThresh, .mainOvervoltage, .wakeEvent, .overtempActive(1'b0),
        .testPinLow, .intPinIn, .mcuResetLine_n, .intPullDownOe_n(), .failOutputs, .mainRegulatorOn,
        .modeState, .modeField, .configPinLevel, .countSelectReadback, .developmentMode, .powerOnFlag,
        .mainOvervoltageFlag, .mainUndervoltageFlag(), .wakeReported, .watchdogFailFlag, .watchdogPeriod);
    sms_mcu_model mcu_u (.core_clk, .rst_n, .mcuResetLine_n, .skipTrig, .slowTrig, .modeReq, .modeSel,
        .cmdValid, .cmdModeWr, .cmdMode, .cmdWdTrigger);
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail("timeout");
            wrap_up();
        end
    end
    task automatic fail(input string msg);
        n_mismatch++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask
    task automatic check_mode(input logic [2:0] got, input sms_mode_t exp);
        num_checks++;
        if (got !== exp) fail($sformatf("mode %0d want %0d", got, exp));
    endtask
    task automatic check_val(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) fail("status value wrong");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // every mode change takes the oldest note
    always @(posedge core_clk) begin
        if (rst_n && modeState !== prevMode) begin
            if (expQ.size() == 0) fail("unexpected mode change");
            else check_mode(modeState, expQ.pop_front());
        end
        prevMode = modeState;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic drain();
        for (int i = 0; i < 3000 && expQ.size() > 0; i++) tick(1);
        if (expQ.size() > 0) fail("mode change missing");
        tick(8);
    endtask
    task automatic send_mode(input logic [1:0] m);
        {modeReq, modeSel} <= {1'b1, m};
        tick(1);
        modeReq <= 1'b0;
    endtask
    task automatic ov_pulse(input logic en);
        {overvoltageResetEnable, mainOvervoltage} <= {en, 1'b1};
        tick(3);
        mainOvervoltage <= 1'b0;
    endtask
    // power-up, wake in init, pin noise
    task automatic power_up(input logic pin, cs, tp, noisy, skip);
        rst_n <= 1'b0;
        {intPinIn, countSelect, testPinLow, skipTrig} <= {pin, cs, tp, skip};
        {mainRegulatorBelowReset, supplyBelowShortThresh} <= 2'b11;
        tick(4);
        rst_n <= 1'b1;
        tick(5);
        {mainRegulatorBelowReset, supplyBelowShortThresh} <= 2'b00;
        for (int i = 0; i < RD + 40; i++) begin
            wakeEvent <= (i == 3);
            if (noisy) intPinIn <= 1'($random(seed));
            tick(1);
        end
        intPinIn <= pin;
    endtask
    initial begin
        rst_n = 1'b0;
        {countSelect, overvoltageResetEnable, powerOnFlagClr, overvoltageFlagClr, mainOvervoltage} = '0;
        {mainRegulatorBelowReset, supplyBelowShortThresh, wakeEvent, testPinLow} = '0;
        {intPinIn, skipTrig, slowTrig, modeReq, modeSel} = '0;
        expQ.push_back(MODE_NORMAL);
        power_up(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        drain();
        check_val(configPinLevel, 1'b1);
        check_val(wakeReported, 1'b0);
        check_val(countSelectReadback, 1'b1);
        ov_pulse(1'b0);
        tick(2);
        check_val(mainOvervoltageFlag, 1'b1);
        check_val(failOutputs, 1'b0);
        $display("power-up done");
        expQ.push_back(MODE_STOP);
        send_mode(MODE_REQ_STOP);
        drain();
        intPinIn <= 1'b0;
        expQ = '{MODE_RESTART, MODE_NORMAL};
        ov_pulse(1'b1);
        drain();
        check_val(failOutputs, 1'b1);
        check_val(modeField === MODE_REQ_NORMAL, 1'b1);
        check_val(watchdogPeriod === WD_PERIOD_DEFAULT, 1'b1);
        check_val(configPinLevel, 1'b0);
        {powerOnFlagClr, intPinIn} <= 2'b11;
        tick(1);
        powerOnFlagClr <= 1'b0;
        expQ = '{MODE_RESTART, MODE_NORMAL};
        send_mode(MODE_REQ_RESET);
        drain();
        check_val(powerOnFlag, 1'b0);
        check_val(configPinLevel, 1'b0);
        $display("relatch done");
        expQ = '{MODE_RESTART, MODE_NORMAL, MODE_FAILSAFE};
        power_up(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        drain();
        check_val(failOutputs, 1'b1);
        check_val(watchdogFailFlag, 1'b1);
        {skipTrig, slowTrig, wakeEvent} <= 3'b011;
        expQ = '{MODE_RESTART, MODE_NORMAL};
        tick(1);
        wakeEvent <= 1'b0;
        drain();
        tick(160);
        slowTrig <= 1'b0;
        $display("fail-safe path done");
        expQ = '{MODE_RESTART, MODE_NORMAL};
        power_up(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        tick(100);
        skipTrig <= 1'b0;
        drain();
        check_val(failOutputs, 1'b1);
        power_up(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        tick(250);
        check_val(developmentMode, 1'b1);
        check_val(watchdogFailFlag, 1'b0);
        expQ.push_back(MODE_NORMAL);
        send_mode(MODE_REQ_SLEEP);
        drain();
        $display("dev mode done");
        expQ.push_back(MODE_NORMAL);
        power_up(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        drain();
        check_val(configPinLevel, 1'b0);
        check_val(countSelectReadback, 1'b0);
        $display("unstable pin done");
        wrap_up();
    end
endmodule
`default_nettype wire
